// *** inc/brc_pkg.sv ***
// Package: register map, field layout and reset values of the board control bank
`default_nettype none
package brc_pkg;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned IDX_W           = 14;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned NUM_CHAN        = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BOARD_COMMAND   = 14'h0064;
  localparam logic [IDX_W-1:0] IDX_CUSTOM_CODE     = 14'h0c3a;
  localparam logic [IDX_W-1:0] IDX_CHANNEL_MAP     = 14'h2af8;
  localparam logic [IDX_W-1:0] IDX_CHANNEL_TALLY   = 14'h2af9;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS      = 14'h2b00;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK        = 14'h2b01;
  localparam logic [IDX_W-1:0] IDX_AUX_OUT_CTRL    = 14'h2b02;
  localparam logic [IDX_W-1:0] IDX_RUN_MAP         = 14'h2b03;

  // Customisation code fields
  localparam int unsigned BASE_MOD_LSB     = 0;
  localparam int unsigned FRONT_MOD_LSB    = 8;
  localparam int unsigned HUB_MOD_LSB      = 16;
  localparam int unsigned MOD_FIELD_W      = 8;
  localparam logic [DATA_W-1:0] BASE_CARD_MOD_FIELD    = 32'h0000_00ff;
  localparam logic [DATA_W-1:0] FRONT_MODULE_MOD_FIELD = 32'h0000_ff00;
  localparam logic [DATA_W-1:0] HUB_MODULE_MOD_FIELD   = 32'h00ff_0000;

  // Commands
  localparam logic [DATA_W-1:0] BOARD_RESET_COMMAND = 32'h0000_0001;

  // Channel enable defaults
  localparam logic [NUM_CHAN-1:0] CHAN_MAP_RESET = 8'h01;

  // Interrupt status bits
  localparam int unsigned IRQ_W              = 3;
  localparam int unsigned ST_BAD_VALUE       = 0;
  localparam int unsigned ST_RUN_STARTED     = 1;
  localparam int unsigned ST_RUN_NO_DATA     = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET     = 3'h0;

  // Auxiliary output control bits
  localparam int unsigned AUX_W              = 2;
  localparam int unsigned AUX_TRIG_OUT       = 0;
  localparam int unsigned AUX_CLK_OUT        = 1;
  localparam logic [AUX_W-1:0] AUX_RESET     = 2'h0;

  // Total on-board sample memory, shared among active channels
  localparam logic [DATA_W-1:0] MEM_TOTAL_SAMPLES = 32'h1000_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO         = 32'h0000_0000;
endpackage : brc_pkg
`default_nettype wire

// *** hdl/brc_board_ctrl.sv ***
// Board reset command, customisation code and channel enable register bank
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module brc_board_ctrl #(
  parameter logic [23:0]                   CUSTOM_CODE   = 24'h00_0000, // Arbitrary; zero means standard
  parameter logic [brc_pkg::NUM_CHAN-1:0]  INSTALLED_MAP = 8'hff
) (
  input  wire logic                          CLOCK_I,
  input  wire logic                          RESET_I,
  input  wire logic [brc_pkg::ADDR_W-1:0]    ADDR_I,
  input  wire logic [brc_pkg::DATA_W-1:0]    WR_DATA_I,
  input  wire logic                          WR_I,
  input  wire logic                          RD_I,
  input  wire logic                          RUN_START_I,
  input  wire logic                          MEM_LOADED_I,
  output logic      [brc_pkg::DATA_W-1:0]    RD_DATA_O,
  output logic      [brc_pkg::NUM_CHAN-1:0]  CHAN_ACTIVE_O,
  output logic      [brc_pkg::DATA_W-1:0]    SEG_SIZE_O,
  output logic                               MEM_VALID_O,
  output logic                               TRIG_OUT_EN_O,
  output logic                               CLK_OUT_EN_O,
  output logic                               SW_RESET_O,
  output logic                               IRQ_O
);
  import brc_pkg::*;

  function automatic logic [3:0] count_bits(input logic [NUM_CHAN-1:0] map);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NUM_CHAN; i++)
      n = n + {3'h0, map[i]};
    return n;
  endfunction : count_bits

  logic [NUM_CHAN-1:0] chan_map;
  logic [NUM_CHAN-1:0] run_map;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_mask;
  logic [AUX_W-1:0]    aux_ctrl;
  logic                sw_rst_q;
  logic                mem_valid;

  // Address decode
  wire logic [IDX_W-1:0] idx        = ADDR_I[ADDR_W-1:ADDR_W-IDX_W];
  wire logic             hit_cmd    = (idx == IDX_BOARD_COMMAND);
  wire logic             hit_custom = (idx == IDX_CUSTOM_CODE);
  wire logic             hit_map    = (idx == IDX_CHANNEL_MAP);
  wire logic             hit_tally  = (idx == IDX_CHANNEL_TALLY);
  wire logic             hit_status = (idx == IDX_IRQ_STATUS);
  wire logic             hit_mask   = (idx == IDX_IRQ_MASK);
  wire logic             hit_aux    = (idx == IDX_AUX_OUT_CTRL);
  wire logic             hit_run    = (idx == IDX_RUN_MAP);

  // Board reset: power-on and software command share one path
  wire logic rst_all  = RESET_I | sw_rst_q;
  wire logic cmd_wr   = WR_I & hit_cmd;
  wire logic reset_go = cmd_wr & (WR_DATA_I == BOARD_RESET_COMMAND);

  // Channel map validation
  wire logic [NUM_CHAN-1:0] new_map   = WR_DATA_I[NUM_CHAN-1:0];
  wire logic [3:0]          new_count = count_bits(new_map);
  wire logic upper_clear = (WR_DATA_I[DATA_W-1:NUM_CHAN] == DATA_ZERO[DATA_W-1:NUM_CHAN]);
  wire logic installed   = ((new_map & ~INSTALLED_MAP) == 8'h00);
  wire logic count_ok    = (new_count == 4'h1) | (new_count == 4'h2) |
                           (new_count == 4'h4) | (new_count == 4'h8);
  wire logic map_wr      = WR_I & hit_map & ~sw_rst_q;
  wire logic map_ok      = upper_clear & installed & count_ok;
  wire logic map_take    = map_wr & map_ok;
  wire logic map_reject  = map_wr & ~map_ok;

  wire logic [3:0] tally     = count_bits(chan_map);
  wire logic [3:0] run_tally = count_bits(chan_map);

  // Segment size per active channel: counts are powers of two, so a shift
  wire logic [1:0] seg_shift = run_tally[3] ? 2'h3 : run_tally[2] ? 2'h2 :
                               run_tally[1] ? 2'h1 : 2'h0;
  wire logic [DATA_W-1:0] seg_size = MEM_TOTAL_SAMPLES >> seg_shift;

  // Interrupt events
  wire logic [IRQ_W-1:0] irq_event = {RUN_START_I & ~mem_valid, RUN_START_I, map_reject};
  wire logic [IRQ_W-1:0] irq_clear = (WR_I & hit_status & ~sw_rst_q) ? WR_DATA_I[IRQ_W-1:0] : 3'h0;
  wire logic [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_event;

  wire logic [DATA_W-1:0] custom_word = {8'h00, CUSTOM_CODE};

  // Read words, each zero-padded to the bus width
  wire logic [DATA_W-1:0] word_map    = {{(DATA_W-NUM_CHAN){1'b0}}, chan_map};
  wire logic [DATA_W-1:0] word_tally  = {{(DATA_W-$bits(tally)){1'b0}}, tally};
  wire logic [DATA_W-1:0] word_status = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
  wire logic [DATA_W-1:0] word_mask   = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
  wire logic [DATA_W-1:0] word_aux    = {{(DATA_W-AUX_W){1'b0}}, aux_ctrl};
  wire logic [DATA_W-1:0] word_run    = {{(DATA_W-NUM_CHAN){1'b0}}, run_map};

  // Read mux; command register and an idle bus read zero
  wire logic [DATA_W-1:0] next_rd_data =
      !RD_I      ? DATA_ZERO :
      hit_custom ? custom_word :
      hit_map    ? word_map :
      hit_tally  ? word_tally :
      hit_status ? word_status :
      hit_mask   ? word_mask :
      hit_aux    ? word_aux :
      hit_run    ? word_run :
      DATA_ZERO;

  // Command strobe becomes a one-cycle board reset
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      sw_rst_q <= 1'b0;
    else
      sw_rst_q <= reset_go;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (rst_all)
    begin
      chan_map <= CHAN_MAP_RESET;
      irq_mask <= IRQ_RESET;
      aux_ctrl <= AUX_RESET;
    end
    else
    begin
      if (map_take)
        chan_map <= new_map;
      if (WR_I & hit_mask)
        irq_mask <= WR_DATA_I[IRQ_W-1:0];
      if (WR_I & hit_aux)
        aux_ctrl <= WR_DATA_I[AUX_W-1:0];
    end
  end

  // Staged map only reaches the outputs at a run start
  always_ff @(posedge CLOCK_I)
  begin
    if (rst_all)
    begin
      run_map    <= CHAN_MAP_RESET;
      SEG_SIZE_O <= MEM_TOTAL_SAMPLES;
    end
    else if (RUN_START_I)
    begin
      run_map    <= chan_map;
      SEG_SIZE_O <= seg_size;
    end
  end

  // Set wins over software clear
  always_ff @(posedge CLOCK_I)
  begin
    if (rst_all)
    begin
      irq_status <= IRQ_RESET;
      mem_valid  <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (MEM_LOADED_I)
        mem_valid <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      RD_DATA_O <= DATA_ZERO;
    else
      RD_DATA_O <= next_rd_data;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (rst_all)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(next_irq_status & irq_mask);
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      SW_RESET_O <= 1'b0;
    else
      SW_RESET_O <= reset_go;
  end

  assign CHAN_ACTIVE_O = run_map;
  assign MEM_VALID_O   = mem_valid;
  assign TRIG_OUT_EN_O = aux_ctrl[AUX_TRIG_OUT];
  assign CLK_OUT_EN_O  = aux_ctrl[AUX_CLK_OUT];

  cmd_reset_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    reset_go |=> sw_rst_q ##1 (chan_map == CHAN_MAP_RESET && !MEM_VALID_O && !TRIG_OUT_EN_O && !CLK_OUT_EN_O))
    else $error("board reset command did not restore defaults");

  reset_defaults_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    sw_rst_q |=> (run_map == CHAN_MAP_RESET && irq_status == IRQ_RESET && !IRQ_O))
    else $error("software reset left state behind");

  bad_value_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (map_reject && !RUN_START_I) |=> ($stable(chan_map) && irq_status[ST_BAD_VALUE]))
    else $error("invalid channel map accepted or not flagged");

  absent_chan_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    ##1 ((chan_map & ~INSTALLED_MAP) == 8'h00))
    else $error("channel map holds an absent channel");

  good_value_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    map_take |=> (chan_map == $past(new_map)))
    else $error("valid channel map not stored");

  run_apply_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RUN_START_I && !sw_rst_q && !map_take) |=> (CHAN_ACTIVE_O == chan_map)
      ##0 (SEG_SIZE_O == (MEM_TOTAL_SAMPLES >> $clog2(count_bits(CHAN_ACTIVE_O)))))
    else $error("run start did not apply map and segment size");

  tally_read_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_tally) |=> (RD_DATA_O == {28'h000_0000, count_bits($past(chan_map))}))
    else $error("tally read wrong");

  cmd_read_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_cmd) |=> (RD_DATA_O == DATA_ZERO && !sw_rst_q))
    else $error("command register read not zero");

  custom_read_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_custom) |=> (RD_DATA_O[HUB_MOD_LSB +: MOD_FIELD_W] == CUSTOM_CODE[HUB_MOD_LSB +: MOD_FIELD_W])
      ##0 (RD_DATA_O[BASE_MOD_LSB +: MOD_FIELD_W] == CUSTOM_CODE[BASE_MOD_LSB +: MOD_FIELD_W]))
    else $error("customisation code read wrong");

  no_data_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RUN_START_I && !MEM_VALID_O && !sw_rst_q) |=> irq_status[ST_RUN_NO_DATA])
    else $error("run without loaded data not flagged");

  sw_pulse_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    reset_go
    |=> SW_RESET_O)
    else $error("board reset pulse missing");

  sw_pulse_end_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !reset_go
    |=> !SW_RESET_O)
    else $error("board reset pulse without command");

  odd_cmd_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (cmd_wr && !reset_go)
    |=> !sw_rst_q)
    else $error("unknown command started a reset");

  aux_reset_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    sw_rst_q
    |=> (aux_ctrl == AUX_RESET && irq_mask == IRQ_RESET))
    else $error("output enables or mask not cleared by reset");

  seg_default_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    sw_rst_q
    |=> (SEG_SIZE_O == MEM_TOTAL_SAMPLES && !MEM_VALID_O))
    else $error("segment size or memory flag not at default");

  mem_loaded_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (MEM_LOADED_I && !sw_rst_q)
    |=> MEM_VALID_O)
    else $error("reload did not mark memory valid");

  mem_hold_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (!MEM_LOADED_I && !MEM_VALID_O)
    |=> !MEM_VALID_O)
    else $error("memory became valid without reload");

  run_hold_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (!RUN_START_I && !sw_rst_q)
    |=> ($stable(CHAN_ACTIVE_O) && $stable(SEG_SIZE_O)))
    else $error("active map changed outside a run start");

  map_hold_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (!map_take && !sw_rst_q)
    |=> $stable(chan_map))
    else $error("channel map changed without a valid write");

  upper_bits_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (map_wr && !upper_clear)
    |=> irq_status[ST_BAD_VALUE])
    else $error("bits above the last channel not refused");

  absent_reject_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (map_wr && !installed)
    |=> ($stable(chan_map) && irq_status[ST_BAD_VALUE]))
    else $error("absent channel accepted");

  single_chan_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (map_wr && upper_clear && installed && new_count == 4'h1)
    |=> (chan_map == $past(new_map)))
    else $error("single channel refused");

  pair_chan_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (map_wr && upper_clear && installed && new_count == 4'h2)
    |=> (chan_map == $past(new_map)))
    else $error("channel pair refused");

  count_reject_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (map_wr && !count_ok)
    |=> irq_status[ST_BAD_VALUE])
    else $error("bad channel count not flagged");

  irq_level_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !sw_rst_q
    |=> (IRQ_O == |(irq_status & $past(irq_mask))))
    else $error("interrupt level wrong");

  run_flag_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RUN_START_I && !sw_rst_q)
    |=> irq_status[ST_RUN_STARTED])
    else $error("run start not flagged");

  status_sticky_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (irq_status[ST_BAD_VALUE] && !sw_rst_q && !(WR_I && hit_status && WR_DATA_I[ST_BAD_VALUE]))
    |=> irq_status[ST_BAD_VALUE])
    else $error("error flag lost without a clear");

  rd_idle_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !RD_I
    |=> (RD_DATA_O == DATA_ZERO))
    else $error("read data outside a read cycle");

  map_read_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_map)
    |=> (RD_DATA_O == {24'h00_0000, $past(chan_map)}))
    else $error("channel map read wrong");

  status_read_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_status)
    |=> (RD_DATA_O[IRQ_W-1:0] == $past(irq_status)))
    else $error("status read wrong");

  run_read_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_run)
    |=> (RD_DATA_O[NUM_CHAN-1:0] == $past(run_map)))
    else $error("applied map read wrong");

  run_map_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RUN_START_I && !sw_rst_q)
    |=> (CHAN_ACTIVE_O == $past(chan_map)))
    else $error("run start applied the wrong map");

  aux_write_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (WR_I && hit_aux && !sw_rst_q)
    |=> (TRIG_OUT_EN_O == $past(WR_DATA_I[AUX_TRIG_OUT]) && CLK_OUT_EN_O == $past(WR_DATA_I[AUX_CLK_OUT])))
    else $error("output enables not taken from write");

  custom_front_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_custom)
    |=> (RD_DATA_O[FRONT_MOD_LSB +: MOD_FIELD_W] == CUSTOM_CODE[FRONT_MOD_LSB +: MOD_FIELD_W]))
    else $error("front module field read wrong");

  custom_std_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (RD_I && hit_custom && CUSTOM_CODE == 24'h00_0000)
    |=> (RD_DATA_O == DATA_ZERO))
    else $error("standard board reports a modification");

  tally_count_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    1'b1
    |=> (tally == 4'h1 || tally == 4'h2 || tally == 4'h4 || tally == 4'h8))
    else $error("tally outside one, two, four or eight");
endmodule : brc_board_ctrl
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the board control register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import brc_pkg::*;
  localparam logic [15:0] A_CMD  = 16'h0190;
  localparam logic [15:0] A_CUST = 16'h30e8;
  localparam logic [15:0] A_MAP  = 16'habe0;
  localparam logic [15:0] A_TAL  = 16'habe4;
  localparam logic [15:0] A_ST   = 16'hac00;
  localparam logic [15:0] A_MSK  = 16'hac04;
  localparam logic [15:0] A_AUX  = 16'hac08;
  localparam logic [15:0] A_RUN  = 16'hac0c;
  logic        clk;
  logic        rst     = 1'b1;
  logic [15:0] addr    = 16'h0000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        run     = 1'b0;
  logic        loaded  = 1'b0;
  wire logic [31:0] rdata;
  wire logic [31:0] seg;
  wire logic [7:0]  act;
  wire logic        mem_ok;
  wire logic        trig_en;
  wire logic        clk_en;
  wire logic        sw_rst;
  wire logic        irq;
  int miscompares = 0;
  int tests_run   = 0;

  brc_board_ctrl i_brc_board_ctrl (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RUN_START_I(run), .MEM_LOADED_I(loaded), .RD_DATA_O(rdata), .CHAN_ACTIVE_O(act),
    .SEG_SIZE_O(seg), .MEM_VALID_O(mem_ok), .TRIG_OUT_EN_O(trig_en), .CLK_OUT_EN_O(clk_en),
    .SW_RESET_O(sw_rst), .IRQ_O(irq));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask : rd_chk

  // Which: 0 starts a run, 1 reports reloaded waveform data
  task automatic pulse(input bit which);
    @(posedge clk);
    run    <= !which;
    loaded <= which;
    @(posedge clk);
    run    <= 1'b0;
    loaded <= 1'b0;
    #1;
  endtask : pulse

  task automatic check_defaults();
    chk("chan_active", {24'h0, act}, 32'h0000_0001);
    chk("seg_size", seg, MEM_TOTAL_SAMPLES);
    rd_chk("custom_code", A_CUST, 32'h0000_0000);
    rd_chk("command_read", A_CMD, 32'h0000_0000);
    rd_chk("map", A_MAP, 32'h0000_0001);
    rd_chk("tally", A_TAL, 32'h0000_0001);
  endtask : check_defaults

  task automatic map_table();
    logic [7:0] maps [4] = '{8'h40, 8'h88, 8'hcc, 8'hff};
    logic [7:0] prev = 8'h01;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(A_MAP, {24'h0, maps[i]});
      #1 chk("active_before_run", {24'h0, act}, {24'h0, prev});
      rd_chk("map", A_MAP, {24'h0, maps[i]});
      rd_chk("tally", A_TAL, 32'h0000_0001 << i);
      pulse(1'b0);
      chk("chan_active", {24'h0, act}, {24'h0, maps[i]});
      chk("seg_size", seg, MEM_TOTAL_SAMPLES >> i);
      rd_chk("run_map", A_RUN, {24'h0, maps[i]});
      prev = maps[i];
    end
    // Three channels is not a legal count; bit 8 names no channel
    wr_reg(A_MAP, 32'h0000_0007);
    rd_chk("map_odd_count", A_MAP, 32'h0000_00ff);
    wr_reg(A_MAP, 32'h0000_0101);
    rd_chk("map_absent_bit", A_MAP, 32'h0000_00ff);
    rd_chk("status", A_ST, 32'h0000_0007);
  endtask : map_table

  task automatic irq_path();
    wr_reg(A_ST, 32'h0000_0007);
    rd_chk("status_cleared", A_ST, 32'h0000_0000);
    wr_reg(A_MSK, 32'h0000_0001);
    wr_reg(A_MAP, 32'h0000_000e);
    rd_chk("status_bad", A_ST, 32'h0000_0001);
    chk("irq_unmasked", {31'h0, irq}, 32'h0000_0001);
    wr_reg(A_ST, 32'h0000_0001);
    rd_chk("status_w1c", A_ST, 32'h0000_0000);
    chk("irq_cleared", {31'h0, irq}, 32'h0000_0000);
    wr_reg(A_MSK, 32'h0000_0000);
    wr_reg(A_MAP, 32'h0000_000e);
    rd_chk("status_bad", A_ST, 32'h0000_0001);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
  endtask : irq_path

  task automatic sw_reset();
    wr_reg(A_AUX, 32'h0000_0003);
    wr_reg(A_MSK, 32'h0000_0001);
    pulse(1'b1);
    chk("mem_valid", {31'h0, mem_ok}, 32'h0000_0001);
    chk("aux_en", {30'h0, clk_en, trig_en}, 32'h0000_0003);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr_reg(A_MAP, 32'h0000_0003);
    pulse(1'b0);
    rd_chk("status_loaded_run", A_ST, 32'h0000_0003);
    wr_reg(A_CMD, 32'h0000_0002);
    rd_chk("map_kept", A_MAP, 32'h0000_0003);
    wr_reg(A_CMD, BOARD_RESET_COMMAND);
    #1 chk("sw_reset_pulse", {31'h0, sw_rst}, 32'h0000_0001);
    @(posedge clk);
    #1 chk("sw_reset_end", {31'h0, sw_rst}, 32'h0000_0000);
    chk("chan_active", {24'h0, act}, 32'h0000_0001);
    chk("seg_size", seg, MEM_TOTAL_SAMPLES);
    chk("mem_valid", {31'h0, mem_ok}, 32'h0000_0000);
    chk("aux_en", {30'h0, clk_en, trig_en}, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk("map", A_MAP, 32'h0000_0001);
    rd_chk("mask", A_MSK, 32'h0000_0000);
    rd_chk("aux", A_AUX, 32'h0000_0000);
    rd_chk("status", A_ST, 32'h0000_0000);
    rd_chk("run_map_reset", A_RUN, 32'h0000_0001);
    pulse(1'b0);
    rd_chk("status_run_no_data", A_ST, 32'h0000_0006);
  endtask : sw_reset

  task automatic summarize();
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Guard against a hang anywhere in the sequence
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_defaults();
    wr_reg(A_CMD, BOARD_RESET_COMMAND);
    map_table();
    irq_path();
    sw_reset();
    summarize();
  end
endmodule : tb
`default_nettype wire
